// ### epsr_cfg.svh
// Constants for the PHY identity and status register slice
// How it works
// - Bit 6 shows fast speed, active low
// - Bit 5 shows slow speed, active low
// - Bit 4 shows duplex, low means full
// - Bit 3 shows receive activity, active low
// - Bit 2 shows link up, active low
// - Bit 1 shows transmit activity, active low
// - Bit 0 shows PHY left power down
// - Six indicators each get a polarity setting
`ifndef EPSR_CFG_SVH
`define EPSR_CFG_SVH
`define EPSR_OFF_IDENT    16'h0B0C
`define EPSR_OFF_STATUS   16'h0B10
`define EPSR_OFF_POLARITY 16'h0B20
`define EPSR_OFF_IRQ_STAT 16'h0B24
`define EPSR_OFF_IRQ_MASK 16'h0B28
`define EPSR_IDENT_RESET  16'h0000
`define EPSR_POL_RESET    6'h00
`define EPSR_MASK_RESET   7'h00
`define EPSR_WE_SHIFT     16
`define EPSR_BIT_FAST     6
`define EPSR_BIT_SLOW     5
`define EPSR_BIT_DUPLEX   4
`define EPSR_BIT_RX       3
`define EPSR_BIT_LINK     2
`define EPSR_BIT_TX       1
`define EPSR_BIT_PWRUP    0
`endif

// ### epsr_pkg.sv
// Types shared by the PHY identity and status register slice
package epsr_pkg;
  typedef logic [31:0] epsr_word_type;   // Bus data word
  typedef logic [6:0]  epsr_stat_type;   // Status layout, seven bits
endpackage

// ### epsr_regs.sv
// PHY identity control and status registers with change interrupts
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "epsr_cfg.svh"
module epsr_regs
  import epsr_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  input  wire logic              phy_fast_speed_n,
  input  wire logic              phy_slow_speed_n,
  input  wire logic              phy_duplex_n,
  input  wire logic              phy_rx_act_n,
  input  wire logic              phy_link_n,
  input  wire logic              phy_tx_act_n,
  input  wire logic              phy_pwrup_done,
  output logic      [3:0]        phy_revision_field,
  output logic      [5:0]        phy_model_field,
  output logic      [5:0]        phy_identifier_upper_field,
  output logic      [5:0]        indicator_polarity,
  output logic                   irq
);

  // Identity word, polarity word and interrupt registers.
  // The status word is sampled once per clock, so software and the
  // change detector see one consistent copy; the price is one cycle of
  // lag between a pin moving and its bit moving.
  // Identity word, polarity word and interrupt registers
  logic [15:0]   ident_q;       // Revision, model, upper id
  logic [15:0]   ident_d;
  logic [5:0]    pol_q;         // Polarity per indicator
  logic [5:0]    pol_d;
  epsr_stat_type stat_q;        // Sampled status word
  epsr_stat_type stat_d;
  epsr_stat_type prev_q;        // Previous status for change detect
  epsr_stat_type ist_q;         // Sticky change flags
  epsr_stat_type ist_d;
  epsr_stat_type mask_q;        // Interrupt enable mask
  logic [31:0]   rdata_d;

  // Address decode
  wire hit_ident = (addr == ADDR_W'(`EPSR_OFF_IDENT));
  wire hit_stat  = (addr == ADDR_W'(`EPSR_OFF_STATUS));
  wire hit_pol   = (addr == ADDR_W'(`EPSR_OFF_POLARITY));
  wire hit_ist   = (addr == ADDR_W'(`EPSR_OFF_IRQ_STAT));
  wire hit_mask  = (addr == ADDR_W'(`EPSR_OFF_IRQ_MASK));

  // Upper half of a write selects which low bits change
  wire [15:0] we_bits = wdata[31:`EPSR_WE_SHIFT];
  assign ident_d = (wr && hit_ident) ?
    ((ident_q & ~we_bits) | (wdata[15:0] & we_bits)) : ident_q;
  assign pol_d = (wr && hit_pol) ?
    ((pol_q & ~we_bits[15:10]) | (wdata[15:10] & we_bits[15:10])) :
    pol_q;

  // Raw active-low indicators, each with its own polarity flip.
  // Polarity bits 15..10 map to tx, rx, duplex, link, slow, fast.
  wire raw_fast   = ~phy_fast_speed_n ^ pol_q[0];
  wire raw_slow   = ~phy_slow_speed_n ^ pol_q[1];
  wire raw_link   = ~phy_link_n       ^ pol_q[2];
  wire raw_duplex = ~phy_duplex_n     ^ pol_q[3];
  wire raw_rx     = ~phy_rx_act_n     ^ pol_q[4];
  wire raw_tx     = ~phy_tx_act_n     ^ pol_q[5];

  // Status word: one means asserted (full duplex for duplex bit)
  always_comb begin
    stat_d = '0;
    stat_d[`EPSR_BIT_FAST]   = raw_fast;
    stat_d[`EPSR_BIT_SLOW]   = raw_slow;
    stat_d[`EPSR_BIT_DUPLEX] = raw_duplex;
    stat_d[`EPSR_BIT_RX]     = raw_rx;
    stat_d[`EPSR_BIT_LINK]   = raw_link;
    stat_d[`EPSR_BIT_TX]     = raw_tx;
    stat_d[`EPSR_BIT_PWRUP]  = phy_pwrup_done;
  end

  // Change events; a set in the clearing read cycle wins
  wire [6:0] chg = stat_q ^ prev_q;
  assign ist_d = ((rd && hit_ist) ? 7'h00 : ist_q) | chg;

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_ident) begin
      rdata_d[15:0] = ident_q;  // Enable half reads as zero
    end else if (hit_stat) begin
      rdata_d[6:0] = stat_q;
    end else if (hit_pol) begin
      rdata_d[15:10] = pol_q;
    end else if (hit_ist) begin
      rdata_d[6:0] = ist_q;
    end else if (hit_mask) begin
      rdata_d[6:0] = mask_q;
    end
  end

  // Register update; prev tracks stat so flags fire on edges only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ident_q <= `EPSR_IDENT_RESET;
      pol_q   <= `EPSR_POL_RESET;
      stat_q  <= 7'h00;
      prev_q  <= 7'h00;
      ist_q   <= 7'h00;
      mask_q  <= `EPSR_MASK_RESET;
      rdata   <= 32'h0000_0000;
      irq     <= 1'b0;
    end else begin
      ident_q <= ident_d;
      pol_q   <= pol_d;
      stat_q  <= stat_d;
      prev_q  <= stat_q;
      ist_q   <= ist_d;
      if (wr && hit_mask) begin
        mask_q <= wdata[6:0];
      end
      rdata   <= rd ? rdata_d : 32'h0000_0000;
      irq     <= |(ist_d & ((wr && hit_mask) ? wdata[6:0] : mask_q));
    end
  end

  // Fields driven to the PHY macro straight from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phy_revision_field         <= 4'h0;
      phy_model_field            <= 6'h00;
      phy_identifier_upper_field <= 6'h00;
      indicator_polarity         <= 6'h00;
    end else begin
      phy_revision_field         <= ident_d[15:12];
      phy_model_field            <= ident_d[11:6];
      phy_identifier_upper_field <= ident_d[5:0];
      indicator_polarity         <= pol_d;
    end
  end

  // Checks.
  // The first group proves that an asserted pin sets its status bit, and that a high duplex pin clears its bit, with
  // the polarity left at its reset value, one cycle after the pin moves.
  // Later groups cover the other level, the inverted polarity, the write
  // enables, the sticky flags and the read port.
  // All checks sleep while reset is low, because the status copy and its
  // delayed twin both restart from zero.
  // Checks
  wire ident_wr = wr && hit_ident;
  sequence fast_low_s;
    !phy_fast_speed_n && !pol_q[0];
  endsequence
  fast_ind_a: assert property (@(posedge clk) disable iff (!rst_n)
    fast_low_s |=> stat_q[6]) else $error("fast bit wrong");
  slow_ind_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!phy_slow_speed_n && !pol_q[1]) |=> stat_q[5])
    else $error("slow bit wrong");
  duplex_ind_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phy_duplex_n && !pol_q[3]) |=> !stat_q[4])
    else $error("duplex bit wrong");
  rx_ind_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!phy_rx_act_n && !pol_q[4]) |=> stat_q[3])
    else $error("rx bit wrong");
  link_ind_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!phy_link_n && !pol_q[2]) |=> stat_q[2])
    else $error("link bit wrong");
  tx_ind_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!phy_tx_act_n && !pol_q[5]) |=> stat_q[1])
    else $error("tx bit wrong");
  pwrup_ind_a: assert property (@(posedge clk) disable iff (!rst_n)
    phy_pwrup_done |=> stat_q[0]) else $error("pwrup bit wrong");
  pol_flip_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phy_link_n && pol_q[2]) |=> stat_q[2])
    else $error("polarity not applied");
  ident_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ident_wr && wdata[31:16] == 16'h0000) |=> $stable(ident_q))
    else $error("ident changed without enable");
  ident_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ident_wr && wdata[31:16] == 16'hFFFF) |=>
    ident_q == $past(wdata[15:0])) else $error("ident not loaded");
  read_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && hit_stat) |=> rdata == {25'h0, $past(stat_q)})
    else $error("status read wrong");
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    irq == |(ist_q & mask_q)) else $error("irq mismatch");

  // Second layer of checks. The level checks above prove that an active
  // pin sets its bit (a high duplex pin clears it); the ones below prove the opposite level,
  // the inverted polarity of every indicator, the write enables of both
  // control words, the sticky flags and the read port.
  // Together they pin each status bit down from both sides, so a bit
  // stuck at one value or wired to a neighbouring pin cannot slip by.
  // A mismatch here points at the decode or the polarity mapping, since
  // the status copy itself is a plain register.
  // These checks take pins and strobes only as triggers; what they test
  // is what the slice itself holds or drives.

  // Idle pins read as clear while polarity is normal.
  // This is the half that catches a status bit stuck at one.
  // Duplex is the odd one: its check here takes a low pin, full duplex, bit set.
  fast_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phy_fast_speed_n && !pol_q[0]) |=> !stat_q[6])
    else $error("fast bit set while idle");
  slow_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phy_slow_speed_n && !pol_q[1]) |=> !stat_q[5])
    else $error("slow bit set while idle");
  duplex_full_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!phy_duplex_n && !pol_q[3]) |=> stat_q[4])
    else $error("full duplex not shown");
  rx_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phy_rx_act_n && !pol_q[4]) |=> !stat_q[3])
    else $error("rx bit set while idle");
  link_down_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phy_link_n && !pol_q[2]) |=> !stat_q[2])
    else $error("link bit set while down");
  tx_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phy_tx_act_n && !pol_q[5]) |=> !stat_q[1])
    else $error("tx bit set while idle");
  pwrup_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    !phy_pwrup_done |=> !stat_q[0])
    else $error("pwrup bit set while powered down");

  // Each polarity bit inverts only its own indicator.
  // A swapped pair of polarity bits would pass the link check above
  // alone, so every indicator is flipped on its own here.
  fast_flip_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phy_fast_speed_n && pol_q[0]) |=> stat_q[6])
    else $error("fast polarity not applied");
  slow_flip_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phy_slow_speed_n && pol_q[1]) |=> stat_q[5])
    else $error("slow polarity not applied");
  duplex_flip_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phy_duplex_n && pol_q[3]) |=> stat_q[4])
    else $error("duplex polarity not applied");
  rx_flip_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phy_rx_act_n && pol_q[4]) |=> stat_q[3])
    else $error("rx polarity not applied");
  tx_flip_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phy_tx_act_n && pol_q[5]) |=> stat_q[1])
    else $error("tx polarity not applied");
  fast_inv_lo_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!phy_fast_speed_n && pol_q[0]) |=> !stat_q[6])
    else $error("fast polarity ignored on low pin");
  link_inv_lo_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!phy_link_n && pol_q[2]) |=> !stat_q[2])
    else $error("link polarity ignored on low pin");

  // Polarity word: the enable half gates each bit, and the copy sent
  // out to the indicators always equals the register, so software and
  // the macro never disagree about which level means asserted.
  pol_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && hit_pol && wdata[31:26] == 6'h00) |=> $stable(pol_q))
    else $error("polarity changed without enable");
  pol_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && hit_pol && wdata[31:26] == 6'h3F) |=>
    pol_q == $past(wdata[15:10])) else $error("polarity not loaded");
  pol_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    indicator_polarity == pol_q)
    else $error("polarity output differs from register");

  // Identity word: only its own write moves it, and the fields sent
  // to the macro mirror it. Revision and model are checked on their own
  // enable bits too, so a shifted enable mask shows up.
  ident_other_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ident_wr |=> $stable(ident_q))
    else $error("ident changed by foreign access");
  rev_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ident_wr && wdata[31:28] == 4'hF) |=>
    ident_q[15:12] == $past(wdata[15:12])) else $error("revision lost");
  model_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ident_wr && wdata[27:22] == 6'h00) |=> $stable(ident_q[11:6]))
    else $error("model changed without enable");
  ident_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    {phy_revision_field, phy_model_field, phy_identifier_upper_field}
      == ident_q)
    else $error("identity fields differ from register");
  ident_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && hit_ident) |=> rdata == {16'h0000, $past(ident_q)})
    else $error("identity read wrong");

  // Sticky flags: a change sets its flag even in the clearing read,
  // and nothing but a read of the flag word drops one. A read with no
  // change pending leaves the word empty.
  sequence stat_change_s;
    chg != 7'h00;
  endsequence
  sequence flag_read_s;
    rd && hit_ist;
  endsequence
  prev_track_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> prev_q == $past(stat_q))
    else $error("change detector lost its copy");
  ist_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    stat_change_s |=> (ist_q & $past(chg)) == $past(chg))
    else $error("change flag not set");
  ist_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(rd && hit_ist) |=> (ist_q & $past(ist_q)) == $past(ist_q))
    else $error("change flag dropped without read");
  ist_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (flag_read_s ##0 chg == 7'h00) |=> ist_q == 7'h00)
    else $error("change flags not cleared by read");

  // Interrupt mask and output: a cleared mask silences the line, and
  // a raised line stays up until the flags are read or the mask moves.
  mask_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && hit_mask) |=> mask_q == $past(wdata[6:0]))
    else $error("mask not loaded");
  mask_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr && hit_mask) |=> $stable(mask_q))
    else $error("mask changed without write");
  irq_masked_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mask_q == 7'h00 && !(wr && hit_mask)) |=> !irq)
    else $error("irq raised while fully masked");
  irq_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (irq && !(rd && hit_ist) && !(wr && hit_mask)) |=> irq)
    else $error("irq dropped while flags pending");

  // Read port: data stand for one cycle after the strobe and read as
  // zero otherwise, so a bus that ORs several slices stays clean.
  read_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rd |=> rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
  read_unmap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && !(hit_ident || hit_stat || hit_pol || hit_ist || hit_mask))
    |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  ist_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && hit_ist) |=> rdata == {25'h0000000, $past(ist_q)})
    else $error("flag read wrong");
  pol_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && hit_pol) |=> rdata == {16'h0000, $past(pol_q), 10'h000})
    else $error("polarity read wrong");
  mask_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && hit_mask) |=> rdata == {25'h0000000, $past(mask_q)})
    else $error("mask read wrong");

endmodule

// ### epsr_phy_model.sv
// PHY macro model driving the active-low indicator pins
`timescale 1ns/1ps
module epsr_phy_model (
  input  wire logic [6:0] st,
  output logic            fast_n,
  output logic            slow_n,
  output logic            dup_n,
  output logic            rx_n,
  output logic            link_n,
  output logic            tx_n,
  output logic            pwrup
);
  // Asserted indicators pull their pin low
  assign fast_n = ~st[6];
  assign slow_n = ~st[5];
  assign dup_n  = ~st[4];
  assign rx_n   = ~st[3];
  assign link_n = ~st[2];
  assign tx_n   = ~st[1];
  assign pwrup  = st[0];
endmodule

// ### tb_epsr_regs.sv
// Self-checking bench for the PHY identity and status slice
`timescale 1ns/1ps
`include "epsr_cfg.svh"
module tb_epsr_regs;
  import epsr_pkg::*;
  logic          clk = 0, rst_n = 0, wr = 0, rd = 0, rd_seen = 0;
  logic [15:0]   addr = '0;
  epsr_word_type wdata = '0, rdata;
  epsr_stat_type st = '0;
  logic          f_n, s_n, d_n, r_n, l_n, t_n, pu, irq;
  logic [3:0]    rev;
  logic [5:0]    mdl, idu, pol;
  logic [63:0]   q[$], e; // Expected {mask, value} per read
  int            error_cnt = 0, comparisons = 0, cyc = 0;
  always #12.5 clk = ~clk;
  epsr_phy_model phy (.st(st), .fast_n(f_n), .slow_n(s_n), .dup_n(d_n),
    .rx_n(r_n), .link_n(l_n), .tx_n(t_n), .pwrup(pu));
  epsr_regs uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .phy_fast_speed_n(f_n),
    .phy_slow_speed_n(s_n), .phy_duplex_n(d_n), .phy_rx_act_n(r_n),
    .phy_link_n(l_n), .phy_tx_act_n(t_n), .phy_pwrup_done(pu),
    .phy_revision_field(rev), .phy_model_field(mdl),
    .phy_identifier_upper_field(idu), .indicator_polarity(pol), .irq(irq));
  task automatic check(string n, epsr_word_type x, epsr_word_type g,
                       epsr_word_type m);
    comparisons++;
    if ((g & m) !== (x & m)) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, x & m, g & m);
    end
  endtask
  // Strobes stay up until the next call or tick lowers them, so
  // back-to-back transfers never assign a strobe twice in one step
  task automatic wr_reg(logic [15:0] a, epsr_word_type d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // Note the expectation before the strobe goes out
  task automatic rd_reg(logic [15:0] a, epsr_word_type x, epsr_word_type m);
    q.push_back({m, x});
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic tick(int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic results;
    $display("Errors %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      e = q.pop_front();
      check("rdata", e[31:0], rdata, e[63:32]);
    end
  end
  // Hang guard, far above the run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    void'($urandom(44817));
    tick(8);
    rst_n <= 1'b1;
    tick(3);
    // Walking one over each indicator, then random mixes
    for (int i = 0; i < 15; i++) begin
      st <= (i < 7) ? 7'(1 << i) : 7'($urandom);
      tick(3);
      rd_reg(`EPSR_OFF_STATUS, {25'h0, st}, '1);
    end
    wr_reg(`EPSR_OFF_POLARITY, 32'hFC00FC00);
    tick(2);
    check("pol", 32'h3F, {26'h0, pol}, 32'h3F);
    rd_reg(`EPSR_OFF_STATUS, {25'h0, st ^ 7'h7E}, '1);
    wr_reg(`EPSR_OFF_POLARITY, 32'hFC000000);
    // Enables gate each low bit, so the middle write changes nothing
    wr_reg(`EPSR_OFF_IDENT, 32'hF0005000);
    wr_reg(`EPSR_OFF_IDENT, 32'h0000FFFF);
    wr_reg(`EPSR_OFF_IDENT, 32'h003F003F);
    tick(1);
    check("rev", 32'h5, {28'h0, rev}, 32'hF);
    check("ids", 32'h3F, {26'h0, mdl, idu}, 32'hFFF);
    rd_reg(`EPSR_OFF_IDENT, 32'h503F, 32'hFFFF);
    rd_reg(16'h0B30, 32'h0, '1);
    // Interrupt: clear, raise, read-clear, then masked
    wr_reg(`EPSR_OFF_IRQ_MASK, 32'h7F);
    rd_reg(`EPSR_OFF_IRQ_STAT, 32'h0, 32'h0);
    tick(2);
    check("irq", 32'h0, {31'h0, irq}, 32'h1);
    st <= st ^ 7'h04;
    tick(5);
    check("irq", 32'h1, {31'h0, irq}, 32'h1);
    rd_reg(`EPSR_OFF_IRQ_STAT, 32'h04, 32'h7F);
    tick(2);
    check("irq", 32'h0, {31'h0, irq}, 32'h1);
    wr_reg(`EPSR_OFF_IRQ_MASK, 32'h0);
    st <= st ^ 7'h04;
    tick(5);
    check("irq", 32'h0, {31'h0, irq}, 32'h1);
    rd_reg(`EPSR_OFF_IRQ_STAT, 32'h04, 32'h7F);
    tick(3);
    results();
  end
endmodule
